/* File: design/pcca_module.sv */
`timescale 1ns/1ps
// One capture/compare module: value register, capture, compare, pin.
module pcca_module
    import pcca_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic tick_i,
    input wire logic [7:0] mode_i,
    input wire logic pin_i,
    input wire logic wr_lo_i,
    input wire logic wr_hi_i,
    input wire logic [7:0] wdata_i,
    output logic [CNT_W-1:0] value_o,
    output logic event_o,
    output logic pin_o
);
    initial begin
        if (CNT_W != 16) begin
            $error("pcca_module supports a 16-bit counter only");
        end
    end

    logic pin_prev_ff;
    logic pwm_ff;
    logic tog_ff;
    logic [CNT_W-1:0] val_ff;
    logic rise;
    logic fall;
    logic cap;
    logic match;

    // ----------------------------------------------------------------
    // Edge detection and compare
    // ----------------------------------------------------------------
    // The pin is already synchronous, so one delay stage suffices.
    assign rise = pin_i & ~pin_prev_ff;
    assign fall = ~pin_i & pin_prev_ff;
    assign cap = (rise & mode_i[PCCA_MM_CAPP]) | (fall & mode_i[PCCA_MM_CAPN]); // [R12]
    // Compare only on a count tick so a stalled counter matches once.
    assign match = mode_i[PCCA_MM_ECOM] & tick_i & (count_i == val_ff); // [R13]
    assign event_o = cap | (match & mode_i[PCCA_MM_MAT]); // [R11]
    assign value_o = val_ff;
    // A module that drives nothing releases its pin high, so that capture can see it.
    assign pin_o = mode_i[PCCA_MM_PWM] ? pwm_ff
        : (mode_i[PCCA_MM_TOG] ? tog_ff : 1'b1); // [R9] [R10] [R17]

    // Input history starts at the pulled-up idle level, so no false edge follows reset.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pin_prev_ff <= 1'b1;
        end else if (ce_i) begin
            pin_prev_ff <= pin_i;
        end
    end

    // Value register: capture wins over a software write in one cycle.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            val_ff <= '0;
        end else if (ce_i) begin
            if (cap) begin
                val_ff <= count_i; // [R19] [R14]
            end else begin
                if (wr_lo_i) begin
                    val_ff[7:0] <= wdata_i;
                end
                if (wr_hi_i) begin
                    val_ff[15:8] <= wdata_i;
                end
            end
        end
    end

    // Toggle output for high-speed output mode; it starts high like the port latch.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            tog_ff <= 1'b1;
        end else if (ce_i && match && mode_i[PCCA_MM_TOG]) begin
            tog_ff <= ~tog_ff; // [R10]
        end
    end

    // Eight-bit PWM: low while count low byte is below the low value byte.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pwm_ff <= 1'b0;
        end else if (ce_i) begin
            pwm_ff <= (count_i[7:0] >= val_ff[7:0]); // [R9] [R14]
        end
    end
endmodule : pcca_module

/* File: design/pcca_top.sv */
`timescale 1ns/1ps
// Programmable counter array: shared counter and five capture/compare modules.
module pcca_top
    import pcca_pkg::*;
#(
    parameter int NUM_MOD = 5,
    parameter int CNT_W = 16
) (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic idle_i,
    input wire logic t0_ovf_i,
    input wire logic [7:0] port1_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic [7:0] port1_o,
    output logic irq_o,
    output logic wdog_reset_o
);
    initial begin
        if (NUM_MOD != 5 || CNT_W != 16) begin
            $error("pcca_top supports five modules and a 16-bit counter only");
        end
    end

    logic [7:0] ctrl_ff;
    logic [7:0] mode_ff;
    logic [7:0] mmode_ff [NUM_MOD];
    logic [CNT_W-1:0] cnt_ff;
    logic [2:0] pre_ff;
    logic [1:0] ext_ff;
    logic [CNT_W-1:0] mval [NUM_MOD];
    logic [NUM_MOD-1:0] mev;
    logic [NUM_MOD-1:0] mpin;
    logic [NUM_MOD-1:0] wr_vlo;
    logic [NUM_MOD-1:0] wr_vhi;
    logic run;
    logic src_pulse;
    logic tick;
    logic ovf;
    logic wr_ctrl;

    // Decode a per-module address from a base.
    function automatic logic [NUM_MOD-1:0] sel_mod(input logic [7:0] a, input logic [7:0] base);
        logic [NUM_MOD-1:0] s;
        s = '0;
        for (int i = 0; i < NUM_MOD; i++) begin
            s[i] = (a == base + 8'(i));
        end
        return s;
    endfunction : sel_mod

    // ----------------------------------------------------------------
    // Count source and tick
    // ----------------------------------------------------------------
    // Prescaler for the two internal oscillator divisions.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pre_ff <= '0;
        end else if (ce_i) begin
            if ((mode_ff[2:1] == PCCA_SRC_DIV6 && pre_ff == PCCA_DIV6_LAST)
                || (mode_ff[2:1] == PCCA_SRC_DIV2 && pre_ff >= PCCA_DIV2_LAST)) begin
                pre_ff <= '0;
            end else begin
                pre_ff <= pre_ff + 3'h1;
            end
        end
    end

    // External input history; the pin must stay at or below osc/4.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ext_ff <= '0;
        end else if (ce_i) begin
            ext_ff <= {ext_ff[0], port1_i[PCCA_EXT_PIN]}; // [R3]
        end
    end

    // Source selection.
    always_comb begin
        case (pcca_src_t'(mode_ff[2:1]))
            PCCA_SRC_DIV6: src_pulse = (pre_ff == PCCA_DIV6_LAST); // [R2]
            PCCA_SRC_DIV2: src_pulse = (pre_ff >= PCCA_DIV2_LAST);
            PCCA_SRC_T0: src_pulse = t0_ovf_i;
            PCCA_SRC_EXT: src_pulse = ext_ff[0] & ~ext_ff[1];
            default: src_pulse = 1'b0;
        endcase
    end

    // Counting needs run set, and idle blocks it when the gate bit is set.
    assign run = ctrl_ff[PCCA_CTRL_RUN] & ~(idle_i & mode_ff[PCCA_MODE_IDLE]); // [R4] [R15]
    assign tick = run & src_pulse;
    assign ovf = tick & (&cnt_ff); // [R20]

    // ----------------------------------------------------------------
    // Shared counter
    // ----------------------------------------------------------------
    // Software may also load the counter bytes.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cnt_ff <= '0;
        end else if (ce_i) begin
            if (sfr_wr_i && sfr_addr_i == PCCA_ADDR_CNT_LO) begin
                cnt_ff[7:0] <= sfr_wdata_i;
            end else if (sfr_wr_i && sfr_addr_i == PCCA_ADDR_CNT_HI) begin
                cnt_ff[15:8] <= sfr_wdata_i;
            end else if (tick) begin
                cnt_ff <= cnt_ff + 16'h0001; // [R1] [R20]
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == PCCA_ADDR_CTRL);
    assign wr_vlo = sfr_wr_i ? sel_mod(sfr_addr_i, PCCA_ADDR_VAL_LO0) : '0;
    assign wr_vhi = sfr_wr_i ? sel_mod(sfr_addr_i, PCCA_ADDR_VAL_HI0) : '0;

    // Control and flags: hardware set wins over software clear.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ctrl_ff <= PCCA_RESET_BYTE;
        end else if (ce_i) begin
            if (wr_ctrl) begin
                // Flags can be written to zero or set; bit 5 stays zero.
                ctrl_ff[PCCA_CTRL_RUN] <= sfr_wdata_i[PCCA_CTRL_RUN]; // [R4]
                ctrl_ff[PCCA_CTRL_OVF] <= sfr_wdata_i[PCCA_CTRL_OVF] | ovf; // [R5]
                ctrl_ff[NUM_MOD-1:0] <= sfr_wdata_i[NUM_MOD-1:0] | mev; // [R6]
            end else begin
                ctrl_ff[PCCA_CTRL_OVF] <= ctrl_ff[PCCA_CTRL_OVF] | ovf; // [R5]
                ctrl_ff[NUM_MOD-1:0] <= ctrl_ff[NUM_MOD-1:0] | mev; // [R6]
            end
        end
    end

    // Counter mode; reserved bits are forced to zero.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            mode_ff <= PCCA_RESET_BYTE;
        end else if (ce_i && sfr_wr_i && sfr_addr_i == PCCA_ADDR_MODE) begin
            mode_ff <= sfr_wdata_i & PCCA_MODE_WMASK; // [R18]
        end
    end

    // Module mode registers.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NUM_MOD; i++) begin
                mmode_ff[i] <= PCCA_RESET_BYTE;
            end
        end else if (ce_i && sfr_wr_i) begin
            for (int i = 0; i < NUM_MOD; i++) begin
                if (sel_mod(sfr_addr_i, PCCA_ADDR_MMODE0)[i]) begin
                    mmode_ff[i] <= sfr_wdata_i & PCCA_MM_WMASK;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Modules
    // ----------------------------------------------------------------
    for (genvar g = 0; g < NUM_MOD; g++) begin : g_mod
        pcca_module #(
            .CNT_W(CNT_W)
        ) u_mod (
            .core_clk_i(core_clk_i),
            .resetn_i(resetn_i),
            .ce_i(ce_i),
            .count_i(cnt_ff),
            .tick_i(tick),
            .mode_i(mmode_ff[g]),
            .pin_i(port1_i[PCCA_PIN_BASE+g]), // [R17]
            .wr_lo_i(wr_vlo[g]),
            .wr_hi_i(wr_vhi[g]),
            .wdata_i(sfr_wdata_i),
            .value_o(mval[g]),
            .event_o(mev[g]),
            .pin_o(mpin[g])
        );
    end

    // ----------------------------------------------------------------
    // Outputs, all registered
    // ----------------------------------------------------------------
    // Read data mux; unmapped addresses read zero.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            sfr_rdata_o <= '0;
        end else if (ce_i) begin
            sfr_rdata_o <= '0;
            if (sfr_addr_i == PCCA_ADDR_CTRL) begin
                sfr_rdata_o <= ctrl_ff;
            end else if (sfr_addr_i == PCCA_ADDR_MODE) begin
                sfr_rdata_o <= mode_ff;
            end else if (sfr_addr_i == PCCA_ADDR_CNT_LO) begin
                sfr_rdata_o <= cnt_ff[7:0]; // [R1]
            end else if (sfr_addr_i == PCCA_ADDR_CNT_HI) begin
                sfr_rdata_o <= cnt_ff[15:8];
            end
            for (int i = 0; i < NUM_MOD; i++) begin
                if (sel_mod(sfr_addr_i, PCCA_ADDR_MMODE0)[i]) begin
                    sfr_rdata_o <= mmode_ff[i];
                end
                if (sel_mod(sfr_addr_i, PCCA_ADDR_VAL_LO0)[i]) begin
                    sfr_rdata_o <= mval[i][7:0]; // [R14]
                end
                if (sel_mod(sfr_addr_i, PCCA_ADDR_VAL_HI0)[i]) begin
                    sfr_rdata_o <= mval[i][15:8];
                end
            end
        end
    end

    // Shared interrupt from all enabled flags.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= (ctrl_ff[PCCA_CTRL_OVF] & mode_ff[PCCA_MODE_OVF_IE]) // [R5] [R7]
                | (|(ctrl_ff[NUM_MOD-1:0] & {mmode_ff[4][PCCA_MM_IE], // [R8]
                mmode_ff[3][PCCA_MM_IE], mmode_ff[2][PCCA_MM_IE],
                mmode_ff[1][PCCA_MM_IE], mmode_ff[0][PCCA_MM_IE]}));
        end
    end

    // Module pins on port 1; other bits stay high as released inputs.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            port1_o <= 8'hff;
        end else if (ce_i) begin
            port1_o <= 8'hff;
            port1_o[PCCA_PIN_BASE +: NUM_MOD] <= mpin; // [R17]
        end
    end

    // Module 4 watchdog: a match while enabled requests a reset pulse.
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            wdog_reset_o <= 1'b0;
        end else if (ce_i) begin
            wdog_reset_o <= mode_ff[PCCA_MODE_WDOG] & mmode_ff[NUM_MOD-1][PCCA_MM_ECOM]
                & mmode_ff[NUM_MOD-1][PCCA_MM_MAT] & tick
                & (cnt_ff == mval[NUM_MOD-1]); // [R16]
        end
    end
endmodule : pcca_top

/* File: inc/pcca_pkg.sv */
// Function
// R1: One free-running 16-bit up counter, read as bytes, times five modules.
// R2: Count source field picks osc/6, osc/2, timer 0 overflow or external pin.
// R3: The outside party keeps external count pulses at or below oscillator/4.
// R4: Counter advances only while run control bit 6 of control register is set.
// R5: Overflow sets flag bit 7; interrupt only when enabled; software clears.
// R6: Control bits 0 to 4 are module flags set by hardware, cleared by software.
// R7: Module flags and overflow flag share one interrupt request.
// R8: Mode bit 0 gates whether the module flag requests an interrupt.
// R9: Mode bit 1 selects pulse-width modulation on the module pin.
// R10: Mode bit 2 inverts the module pin on each compare equality.
// R11: Mode bit 3 sets the module flag on compare equality.
// R12: Mode bit 4 captures falling edges, bit 5 rising edges, both either.
// R13: Mode bit 6 enables the comparator against the stored value.
// R14: Each module holds a 16-bit capture, compare and duty value.
// R15: Idle gate bit 7 of counter mode stops the counter during idle when set.
// R16: Counter mode bit 6 enables the module 4 watchdog function.
// R17: Module n uses port 1 bit 3+n as input or output.
// R18: Software writes zero to reserved counter mode bits 5 to 3.
// R19: A valid enabled edge copies the counter into the module value bytes.
// R20: The counter wraps from all ones to zero, which is the overflow event.
package pcca_pkg;
    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] PCCA_ADDR_CTRL = 8'hd8;
    localparam logic [7:0] PCCA_ADDR_MODE = 8'hd9;
    localparam logic [7:0] PCCA_ADDR_MMODE0 = 8'hda;
    localparam logic [7:0] PCCA_ADDR_CNT_LO = 8'he9;
    localparam logic [7:0] PCCA_ADDR_CNT_HI = 8'hf9;
    localparam logic [7:0] PCCA_ADDR_VAL_LO0 = 8'hea;
    localparam logic [7:0] PCCA_ADDR_VAL_HI0 = 8'hfa;
    localparam logic [7:0] PCCA_RESET_BYTE = 8'h00;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PCCA_CTRL_OVF = 7;
    localparam int PCCA_CTRL_RUN = 6;
    localparam int PCCA_MODE_IDLE = 7;
    localparam int PCCA_MODE_WDOG = 6;
    localparam int PCCA_MODE_SRC_LO = 1;
    localparam int PCCA_MODE_OVF_IE = 0;
    localparam int PCCA_MM_IE = 0;
    localparam int PCCA_MM_PWM = 1;
    localparam int PCCA_MM_TOG = 2;
    localparam int PCCA_MM_MAT = 3;
    localparam int PCCA_MM_CAPN = 4;
    localparam int PCCA_MM_CAPP = 5;
    localparam int PCCA_MM_ECOM = 6;
    localparam int PCCA_PIN_BASE = 3;
    localparam int PCCA_EXT_PIN = 2;
    localparam logic [7:0] PCCA_MODE_WMASK = 8'hc7;
    localparam logic [7:0] PCCA_MM_WMASK = 8'h7f;
    localparam logic [7:0] PCCA_CTRL_WMASK = 8'hc0;
    // ----------------------------------------------------------------
    // Count source codes and prescale
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PCCA_SRC_DIV6 = 2'h0,
        PCCA_SRC_DIV2 = 2'h1,
        PCCA_SRC_T0 = 2'h2,
        PCCA_SRC_EXT = 2'h3
    } pcca_src_t;
    localparam logic [2:0] PCCA_DIV6_LAST = 3'h5;
    localparam logic [2:0] PCCA_DIV2_LAST = 3'h1;
    localparam logic [2:0] PCCA_EXT_SYNC_LAST = 3'h1;
endpackage : pcca_pkg

/* File: test/pcca_pin_model.sv */
`timescale 1ns/1ps
// Port 1 from outside: the count input and the five module pins.
module pcca_pin_model (
    input wire logic core_clk_i,
    input wire logic ext_on_i,
    input wire logic [4:0] pin_lvl_i,
    input wire logic [7:0] drive_i,
    output logic [7:0] pins_o
);
    logic ph_ff = 1'b0;
    logic eci_ff = 1'b0;
    // Count input flips every two cycles, so pulses never come faster than a quarter rate.
    always_ff @(posedge core_clk_i) begin
        if (ext_on_i) begin
            ph_ff <= ~ph_ff;
            eci_ff <= ph_ff ? ~eci_ff : eci_ff;
        end
    end
    // Pins are pulled up; a pin is low where either side pulls it low.
    assign pins_o = {pin_lvl_i, eci_ff, 2'h3} & drive_i;
endmodule : pcca_pin_model

/* File: test/pcca_props.sv */
`timescale 1ns/1ps
// Register port and pin checks, seen from the top ports only.
module pcca_props (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [7:0] port1_o,
    input wire logic irq_o,
    input wire logic wdog_reset_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    // Any address outside this set must read back as zero.
    function automatic logic mapped(input logic [7:0] a);
        return a inside {8'hd8, 8'hd9, [8'hda:8'hde], 8'he9, 8'hf9, [8'hea:8'hee], [8'hfa:8'hfe]};
    endfunction : mapped
    a_reset_rest: assert property (disable iff (1'b0)
        !resetn_i && ce_i |=> sfr_rdata_o == 8'h00 && port1_o == 8'hff && !irq_o && !wdog_reset_o)
        else $error("outputs not at rest after reset");
    a_unmapped_zero: assert property (ce_i && !mapped(sfr_addr_i) |=> sfr_rdata_o == 8'h00)
        else $error("unmapped address read nonzero");
    a_ctrl_reserved: assert property (ce_i && sfr_addr_i == 8'hd8 |=> !sfr_rdata_o[5])
        else $error("control bit 5 read nonzero");
    a_mode_reserved: assert property (ce_i && sfr_addr_i == 8'hd9 |=> sfr_rdata_o[5:3] == 3'h0)
        else $error("counter mode reserved bits nonzero");
    a_mmode_reserved: assert property (ce_i && sfr_addr_i inside {[8'hda:8'hde]}
        |=> !sfr_rdata_o[7]) else $error("module mode bit 7 nonzero");
    a_mode_readback: assert property (ce_i && sfr_wr_i && sfr_addr_i == 8'hd9
        ##1 ce_i && sfr_addr_i == 8'hd9 |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & 8'hc7))
        else $error("counter mode readback wrong");
    a_run_readback: assert property (ce_i && sfr_wr_i && sfr_addr_i == 8'hd8
        ##1 ce_i && sfr_addr_i == 8'hd8 |=> ((sfr_rdata_o ^ $past(sfr_wdata_i, 2)) & 8'h40) == 8'h00)
        else $error("run control readback wrong");
    a_port_fixed: assert property (port1_o[2:0] == 3'h7)
        else $error("non-module port bits not high");
    a_freeze_ce: assert property (!ce_i |=> $stable(sfr_rdata_o) && $stable(port1_o) && $stable(irq_o))
        else $error("outputs moved with clock enable low");
    a_wdog_pulse: assert property (wdog_reset_o && ce_i |=> !wdog_reset_o)
        else $error("watchdog pulse longer than one cycle");
endmodule : pcca_props

/* File: test/tb_pcca_top.sv */
`timescale 1ns/1ps
// Bench for the counter array, driven through its register port.
module tb_pcca_top;
    import pcca_pkg::*;
    logic core_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic idle_i = 1'b0;
    logic t0_ovf_i = 1'b0;
    logic sfr_wr_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic ext_on = 1'b0;
    logic [4:0] pins = 5'h1f;
    logic [7:0] port1_i, sfr_rdata_o, port1_o, v;
    logic irq_o, wdog_reset_o, seen;
    logic [7:0] lo [4] = '{8'h07, 8'h17, 8'h06, 8'h0a};
    logic [7:0] hi [4] = '{8'h0a, 8'h1b, 8'h06, 8'h0d};
    logic [7:0] mv [3] = '{8'h10, 8'h10, 8'h08};
    logic [7:0] mm [3] = '{8'h49, 8'h08, 8'h44};
    logic [7:0] ra [8] = '{8'hd8, 8'hd9, 8'hda, 8'he9, 8'hf9, 8'hea, 8'hfe, 8'h00};
    int n_mismatch = 0;
    int comparisons = 0;
    pcca_top uut (.core_clk_i, .resetn_i, .ce_i, .idle_i, .t0_ovf_i, .port1_i, .sfr_addr_i,
        .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .port1_o, .irq_o, .wdog_reset_o);
    pcca_pin_model u_pins (.core_clk_i, .ext_on_i(ext_on), .pin_lvl_i(pins),
        .drive_i(port1_o), .pins_o(port1_i));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic tk(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        sfr_addr_i <= a;
        sfr_wr_i <= 1'b1;
        sfr_wdata_i <= d;
        @(posedge core_clk_i);
        sfr_wr_i <= 1'b0;
    endtask : wr
    // Read data is registered, so it is taken a full cycle after the address is seen.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        sfr_addr_i <= a;
        tk(2);
        d = sfr_rdata_o;
    endtask : rd
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_rng(input logic [7:0] g, input logic [7:0] l, input logic [7:0] h);
        comparisons++;
        if ((g >= l && g <= h) !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] %0t count %h outside %h..%h", $time, g, l, h);
        end
    endtask : chk_rng
    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d & m, e);
    endtask : rc
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    // Free-running clock and a bound on the whole run.
    initial begin
        forever #20 core_clk_i = ~core_clk_i;
    end
    initial begin
        #160000;
        n_mismatch++;
        summarize();
    end
    // Main sequence; writes to counter mode keep its reserved bits at zero.
    initial begin
        repeat (12) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        foreach (ra[i]) rc(ra[i], 8'hff, 8'h00);
        chk(port1_o, 8'hff);
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            wr(8'he9, 8'h00);
            wr(8'hf9, 8'h00);
            wr(PCCA_ADDR_MODE, {5'h00, 2'(s), 1'b0});
            wr(PCCA_ADDR_CTRL, 8'h40);
            ext_on <= (s == 3);
            for (int i = 0; i < 48; i++) begin
                @(posedge core_clk_i);
                t0_ovf_i <= (s == 2) && (i % 8 == 4);
            end
            ext_on <= 1'b0;
            wr(PCCA_ADDR_CTRL, 8'h00);
            rd(8'he9, v);
            chk_rng(v, lo[s], hi[s]);
            tk(8);
            rc(8'he9, 8'hff, v);
        end
        wr(8'he9, 8'h00);
        wr(PCCA_ADDR_MODE, 8'h82);
        idle_i <= 1'b1;
        wr(PCCA_ADDR_CTRL, 8'h40);
        tk(20);
        wr(PCCA_ADDR_CTRL, 8'h00);
        idle_i <= 1'b0;
        rc(8'he9, 8'hff, 8'h00);
        $display("test count source done");
        wr(8'hf9, 8'hff);
        wr(8'he9, 8'hfe);
        wr(PCCA_ADDR_MODE, 8'h02);
        wr(PCCA_ADDR_CTRL, 8'h40);
        tk(10);
        rc(PCCA_ADDR_CTRL, 8'hc0, 8'hc0);
        rc(8'hf9, 8'hff, 8'h00);
        chk({7'h00, irq_o}, 8'h00);
        wr(PCCA_ADDR_MODE, 8'h03);
        tk(2);
        chk({7'h00, irq_o}, 8'h01);
        @(posedge core_clk_i);
        ce_i <= 1'b0;
        tk(4);
        @(posedge core_clk_i);
        ce_i <= 1'b1;
        wr(PCCA_ADDR_CTRL, 8'h00);
        tk(2);
        chk({7'h00, irq_o}, 8'h00);
        $display("test overflow done");
        wr(8'he9, 8'h00);
        wr(8'hf9, 8'h00);
        wr(PCCA_ADDR_MODE, 8'h02);
        for (int m = 0; m < 3; m++) begin
            wr(8'hea + 8'(m), mv[m]);
            wr(8'hfa + 8'(m), 8'h00);
            wr(8'hda + 8'(m), mm[m]);
        end
        wr(PCCA_ADDR_CTRL, 8'h40);
        tk(50);
        rc(PCCA_ADDR_CTRL, 8'h1f, 8'h01);
        chk({7'h00, irq_o}, 8'h01);
        chk(port1_o & 8'h20, 8'h00);
        wr(8'hda, 8'h48);
        wr(PCCA_ADDR_CTRL, 8'h01);
        tk(2);
        chk({7'h00, irq_o}, 8'h00);
        wr(PCCA_ADDR_CTRL, 8'h00);
        wr(8'hdb, 8'h42);
        wr(8'heb, 8'h80);
        wr(8'he9, 8'h00);
        tk(3);
        chk(port1_o & 8'h10, 8'h00);
        wr(8'he9, 8'h90);
        tk(3);
        chk(port1_o & 8'h10, 8'h10);
        $display("test compare done");
        wr(8'he9, 8'h34);
        wr(8'hf9, 8'h12);
        wr(8'hdd, 8'h20);
        wr(8'hde, 8'h10);
        @(posedge core_clk_i);
        pins <= 5'h07;
        tk(4);
        rc(PCCA_ADDR_CTRL, 8'h18, 8'h10);
        @(posedge core_clk_i);
        pins <= 5'h1f;
        tk(4);
        rc(PCCA_ADDR_CTRL, 8'h18, 8'h18);
        rc(8'hed, 8'hff, 8'h34);
        rc(8'hfd, 8'hff, 8'h12);
        rc(8'hee, 8'hff, 8'h34);
        rc(8'hfe, 8'hff, 8'h12);
        $display("test capture done");
        wr(PCCA_ADDR_CTRL, 8'h00);
        wr(8'hde, 8'h48);
        wr(8'hee, 8'h05);
        wr(8'hfe, 8'h00);
        wr(8'he9, 8'h00);
        wr(8'hf9, 8'h00);
        wr(PCCA_ADDR_MODE, 8'h42);
        wr(PCCA_ADDR_CTRL, 8'h40);
        seen = 1'b0;
        repeat (40) begin
            tk(1);
            seen |= (wdog_reset_o === 1'b1);
        end
        chk({7'h00, seen}, 8'h01);
        wr(PCCA_ADDR_CTRL, 8'h00);
        $display("test watchdog done");
        summarize();
    end
endmodule : tb_pcca_top
bind pcca_top pcca_props u_props (.core_clk_i, .resetn_i, .ce_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .sfr_rdata_o, .port1_o, .irq_o, .wdog_reset_o);
